//--- design/asd_decoder.v
// address extension and internal target decode
// Function
// - copy cpu bit 19 onto bus bits 23:20
// - register base nibble is map bit then 111
// - map bit clear: base 7FF000, locked till reset
// - range 080000 to F7FFFF never generated
// - unimplemented blocks go to external bus
// - ram placed by programmable base register
// - vectors fetched only from bank 0
// - vectors hold 16-bit handler addresses
// - sixteen banks contiguous in 20-bit space
`timescale 1ns/1ps
`default_nettype none
`include "asd_defs.vh"
module asd_decoder #(
  parameter RAM_SPAN_BITS = 11,
  parameter RAM_EN_RST = 1'b1
) (
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  input wire clk_en,
  // processor request
  input wire cpu_req,
  input wire [`ASD_CPU_AW-1:0] cpu_addr,
  input wire cpu_vec_fetch,
  input wire [2:0] cpu_fc,
  // configuration writes from the integration and ram control blocks
  input wire module_map_bit_wr,
  input wire module_map_bit_val,
  input wire ram_base_wr,
  input wire [`ASD_BUS_AW-1:0] ram_base_val,
  input wire ram_en_val,
  // internal module bus request
  output reg internal_module_bus_req_ff,
  output reg [`ASD_BUS_AW-1:0] internal_module_bus_addr_ff,
  output reg [2:0] target_ff,
  output reg sel_regs_ff,
  output reg sel_ram_ff,
  output reg sel_ext_ff,
  output reg [2:0] function_code_outputs_ff,
  output reg vec_fault_ff,
  // state view
  output reg module_map_bit_ff,
  output reg map_locked_ff,
  output reg [`ASD_BUS_AW-1:0] ram_base_ff
);
  // ram window enable, off until a base is written
  reg ram_en_ff;
  // decode intermediates
  reg [`ASD_BUS_AW-1:0] bus_addr;
  reg vec_off_bank;
  reg [3:0] reg_nib;
  reg [`ASD_BUS_AW-1:0] reg_base;
  reg [2:0] nxt_target;
  reg nxt_fault;
  reg nxt_map;
  reg nxt_lock;
  // window results
  wire reg_hit;
  wire ram_hit;

  // extension: bit 19 fans out to the top nibble
  always @*
  begin
    bus_addr = {{4{cpu_addr[`ASD_EXT_MSB]}}, cpu_addr};
    reg_nib = {module_map_bit_ff, `ASD_REG_NIB_LOW};
    // low twelve bits of the base are ignored by the window
    reg_base = {reg_nib, 20'hF_F000};
  end

  // register block window at M111 nibble
  asd_window_match #(
    .AW(`ASD_BUS_AW),
    .SPAN_BITS(`ASD_REG_BLK_AW)
  ) u_reg_win (
    .addr(bus_addr),
    .base(reg_base),
    .hit(reg_hit)
  );

  // ram window from programmable base
  asd_window_match #(
    .AW(`ASD_BUS_AW),
    .SPAN_BITS(RAM_SPAN_BITS)
  ) u_ram_win (
    .addr(bus_addr),
    .base(ram_base_ff),
    .hit(ram_hit)
  );

  // target priority: regs, ram, then external
  always @*
  begin
    nxt_target = `ASD_TGT_NONE;
    nxt_fault = 1'b0;
    // vectors cannot be relocated, so any bank but 0 is a fault
    vec_off_bank = cpu_vec_fetch && (cpu_addr[`ASD_BANK_MSB:`ASD_BANK_LSB] != `ASD_VEC_BANK);
    if (cpu_req)
    begin
      // a faulted vector fetch drives no target and no bus request
      if (vec_off_bank)
      begin
        // vectors sit in bank 0 only; a fetch elsewhere is flagged
        nxt_fault = 1'b1;
      end
      else if (reg_hit)
        nxt_target = `ASD_TGT_REGS;
      else if (ram_en_ff && ram_hit)
        nxt_target = `ASD_TGT_RAM;
      else if (cpu_vec_fetch)
        nxt_target = `ASD_TGT_VEC;
      else
        nxt_target = `ASD_TGT_EXT;
    end
  end

  // once cleared, the map bit holds until reset since the lock sets with it
  always @*
  begin
    nxt_map = module_map_bit_ff;
    nxt_lock = map_locked_ff;
    // writing one while unlocked keeps the block at the top
    if (module_map_bit_wr && !map_locked_ff)
    begin
      nxt_map = module_map_bit_val;
      nxt_lock = !module_map_bit_val;
    end
  end

  // map bit and its lock; the lock only sets, reset is the way out
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      module_map_bit_ff <= `ASD_MMAP_RST;
      map_locked_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      module_map_bit_ff <= nxt_map;
      map_locked_ff <= nxt_lock;
    end
  end

  // ram placement; window stays off until software gives it a base
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ram_base_ff <= `ASD_RAM_BASE_RST;
      ram_en_ff <= 1'b0;
    end
    else if (clk_en && ram_base_wr)
    begin
      ram_base_ff <= ram_base_val;
      ram_en_ff <= ram_en_val;
    end
  end

  // bus request and extended address, one cycle behind the processor
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      internal_module_bus_req_ff <= 1'b0;
      internal_module_bus_addr_ff <= 24'h00_0000;
    end
    else if (clk_en)
    begin
      internal_module_bus_req_ff <= cpu_req && !nxt_fault;
      internal_module_bus_addr_ff <= bus_addr;
    end
  end

  // target code and selects from one decode, so they never disagree
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      target_ff <= `ASD_TGT_NONE;
      sel_regs_ff <= 1'b0;
      sel_ram_ff <= 1'b0;
      sel_ext_ff <= 1'b0;
      vec_fault_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      target_ff <= nxt_target;
      sel_regs_ff <= (nxt_target == `ASD_TGT_REGS);
      sel_ram_ff <= (nxt_target == `ASD_TGT_RAM);
      // bank 0 vectors with no internal hit are read off chip
      sel_ext_ff <= (nxt_target == `ASD_TGT_EXT) || (nxt_target == `ASD_TGT_VEC);
      vec_fault_ff <= nxt_fault;
    end
  end

  // passed out so outside logic can split program and data
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      function_code_outputs_ff <= 3'h0;
    end
    else if (clk_en)
    begin
      function_code_outputs_ff <= cpu_fc;
    end
  end
endmodule // asd_decoder
`default_nettype wire

//--- design/asd_defs.vh
// constants for the address space decoder
`ifndef ASD_DEFS_VH
`define ASD_DEFS_VH
`define ASD_CPU_AW 20
`define ASD_BUS_AW 24
`define ASD_EXT_MSB 19
`define ASD_REG_NIB_LOW 3'h7
`define ASD_REG_BLK_AW 12
`define ASD_RAM_BASE_RST 24'h00_0000
`define ASD_MMAP_RST 1'b1
`define ASD_BANK_MSB 19
`define ASD_BANK_LSB 16
`define ASD_VEC_BANK 4'h0
`define ASD_TGT_NONE 3'h0
`define ASD_TGT_REGS 3'h1
`define ASD_TGT_RAM 3'h2
`define ASD_TGT_EXT 3'h3
`define ASD_TGT_VEC 3'h4
`endif

//--- design/asd_window_match.v
// base and size window comparator
`timescale 1ns/1ps
`default_nettype none
module asd_window_match #(
  parameter AW = 24,
  parameter SPAN_BITS = 12
) (
  // address under test
  input wire [AW-1:0] addr,
  // window base, low bits ignored
  input wire [AW-1:0] base,
  // result
  output wire hit
);
  // block is aligned to its own size, so only upper bits compare
  assign hit = (addr[AW-1:SPAN_BITS] == base[AW-1:SPAN_BITS]);
endmodule // asd_window_match
`default_nettype wire

//--- tb/asd_chk_asserts.sv
// decoder port assertions
`timescale 1ns/1ps
`default_nettype none
module asd_chk (
  // watched ports
  input wire logic core_clk, rst_b, clk_en, cpu_req, cpu_vec_fetch, ram_base_wr, sel_regs_ff, sel_ext_ff,
  input wire logic internal_module_bus_req_ff, vec_fault_ff, module_map_bit_ff,
  input wire logic [19:0] cpu_addr,
  input wire logic [23:0] ram_base_val, ram_base_ff, internal_module_bus_addr_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // taken plain request, its bus address, register window hit
  wire ov = clk_en && cpu_req && !cpu_vec_fetch;
  wire [23:0] ea = {{4{cpu_addr[19]}}, cpu_addr};
  wire rg = cpu_addr[19:12] == 8'hFF;
  a_bus_ext: assert property (ov |=> internal_module_bus_addr_ff == $past(ea)) else $error("no ext");
  a_gap_free:
    assert property (internal_module_bus_req_ff |-> internal_module_bus_addr_ff[23:19] inside {5'h00, 5'h1F})
      else $error("gap");
  a_regs_hit: assert property (ov && rg && module_map_bit_ff |=> sel_regs_ff) else $error("regs");
  a_regs_gone: assert property (!module_map_bit_ff |=> !sel_regs_ff && !module_map_bit_ff) else $error("map");
  a_map_reset: assert property ($rose(rst_b) |-> module_map_bit_ff) else $error("map reset");
  a_ext_route:
    assert property (ov && !rg && ea[23:11] != ram_base_ff[23:11] |=> sel_ext_ff) else $error("ext");
  a_ram_load:
    assert property (clk_en && ram_base_wr |=> ram_base_ff == $past(ram_base_val)) else $error("ram");
  a_vec_bank:
    assert property (clk_en && cpu_req && cpu_vec_fetch |=> vec_fault_ff == ($past(cpu_addr[19:16]) != 4'h0)
      && internal_module_bus_req_ff != vec_fault_ff) else $error("vector");
  // main scenarios reached
  cover property (sel_regs_ff);
  cover property (vec_fault_ff);
  cover property (!module_map_bit_ff);
endmodule // asd_chk
bind asd_decoder asd_chk u_chk (.*);
`default_nettype wire

//--- tb/asd_ext_mem.sv
// external memory model behind the decoder
`timescale 1ns/1ps
`default_nettype none
module asd_ext_mem (
  // bus side
  input wire logic clk, sel,
  input wire logic [2:0] fc,
  // observed traffic
  output logic [7:0] hits,
  output logic prog
);
  // program space picked from the function code
  assign prog = fc[1];
  // count external cycles; wraps, runs are short
  initial hits = 8'h00;
  always @(posedge clk) if (sel) hits <= hits + 8'h01;
endmodule // asd_ext_mem
`default_nettype wire

//--- tb/tb_address_space_decoder.sv
// bench for the address space decoder
`timescale 1ns/1ps
`default_nettype none
module tb_address_space_decoder;
  logic clk = 0, rst_b = 0, req = 0, vec = 0, mwr = 0, mv = 0, rwr = 0;
  logic [19:0] a = 0;
  wire ir, sr, sm, se, vf, mm, pg, lk;
  wire [23:0] ba, rbo;
  wire [7:0] hits;
  wire [2:0] fco, tg;
  int num_errors = 0, n_tests = 0;
  asd_decoder dut (.core_clk(clk), .rst_b(rst_b), .clk_en(1'b1), .cpu_req(req), .cpu_addr(a), .cpu_vec_fetch(vec),
    .cpu_fc(3'h6), .module_map_bit_wr(mwr), .module_map_bit_val(mv), .ram_base_wr(rwr), .ram_base_val(24'h01_0000),
    .ram_en_val(1'b1), .internal_module_bus_req_ff(ir), .internal_module_bus_addr_ff(ba), .target_ff(tg),
    .sel_regs_ff(sr), .sel_ram_ff(sm), .sel_ext_ff(se), .function_code_outputs_ff(fco), .vec_fault_ff(vf),
    .module_map_bit_ff(mm), .map_locked_ff(lk), .ram_base_ff(rbo));
  asd_ext_mem u_mem (.clk(clk), .sel(se), .fc(fco), .hits(hits), .prog(pg));
  initial forever #4 clk = ~clk;
  task automatic chk(string n, int e, logic [23:0] g);
    n_tests++;
    if (g !== e[23:0])
    begin
      num_errors++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  // one cycle of inputs, c is vec, map write, map value, ram write
  task automatic go(logic [19:0] ad, logic [3:0] c);
    @(posedge clk);
    req <= !(c[2] | c[0]);
    a <= ad;
    {vec, mwr, mv, rwr} <= c;
    @(posedge clk);
    {req, vec, mwr, rwr} <= 4'h0;
    #1;
  endtask
  task automatic t_ext;
    go(20'h8_0000, 4'h0);
    chk("addr", 'hF8_0000, ba);
    chk("ext", 1, se);
    chk("tgt", 3, tg);
    chk("fc", 6, fco);
    chk("prog", 1, pg);
    go(20'h7_FFFF, 4'h0);
    chk("top", 'h07_FFFF, ba);
    go(20'hF_F000, 4'h0);
    chk("regs", 1, sr);
    chk("tregs", 1, tg);
  endtask
  task automatic t_ram;
    go(20'h0_0000, 4'h1);
    chk("base", 'h01_0000, rbo);
    go(20'h1_0400, 4'h0);
    chk("ram", 1, sm);
  endtask
  task automatic t_vec;
    go(20'h0_0010, 4'h8);
    chk("vok", 1, ir);
    chk("tvec", 4, tg);
    chk("vext", 1, se);
    go(20'h2_0010, 4'h8);
    chk("vfault", 1, vf);
  endtask
  task automatic t_map;
    go(20'h0_0000, 4'h4);
    chk("map", 0, mm);
    chk("locked", 1, lk);
    go(20'hF_F000, 4'h0);
    chk("hidden", 0, sr);
    go(20'h0_0000, 4'h6);
    chk("lock", 0, mm);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk("mapreset", 1, mm);
    t_ext;
    t_ram;
    t_vec;
    t_map;
    chk("hits", 4, hits);
    final_report;
  end
  // watchdog against a hang
  initial
  begin
    #2000;
    num_errors++;
    final_report;
  end
endmodule // tb_address_space_decoder
`default_nettype wire
